// file: stoim_chan_filter.sv
// one request channel: synchroniser and low-going filter
// assumes an asynchronous pin on input; output stays on mclk
`timescale 1ns/100ps
`include "stoim_defs.svh"

module stoim_chan_filter #(
    parameter int FILTER_CYC = `STOIM_FILTER_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pin,
    output logic level
);
    // ------------------------------------------------------------
    // synchroniser and filter
    // ------------------------------------------------------------
    logic sync1_reg;
    logic sync2_reg;
    logic [31:0] low_cnt_reg;

    initial begin
        if (FILTER_CYC < 2) $error("filter too short");
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= `STOIM_RST_LEVEL;
            sync2_reg <= `STOIM_RST_LEVEL;
        end else begin
            sync1_reg <= pin;
            sync2_reg <= sync1_reg;
        end
    end

    // high passes at once; low must persist, so short test pulses vanish
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_reg <= 32'h0;
            level <= 1'b0;
        end else if (sync2_reg) begin
            low_cnt_reg <= 32'h0;
            level <= 1'b1;
        end else if (low_cnt_reg >= 32'(FILTER_CYC - 1)) begin
            level <= 1'b0;
        end else begin
            low_cnt_reg <= low_cnt_reg + 32'h1;
        end
    end

    a_low_needs_filter: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(level) |-> low_cnt_reg >= 32'(FILTER_CYC - 1))
        else $error("channel dropped before filter time");
endmodule // stoim_chan_filter

// file: stoim_defs.svh
// timing constants and reset values for the torque-off input monitor
// assumes a 100 MHz mclk; counts are derived from printed times
`ifndef STOIM_DEFS_SVH
`define STOIM_DEFS_SVH

`define STOIM_CLK_MHZ 100
`define STOIM_IGNORE_US 2000
`define STOIM_FILTER_US 6000
`define STOIM_MISMATCH_MIN_MS 1600
`define STOIM_MISMATCH_MAX_MS 3000
// threshold sits between the two detection times
`define STOIM_MISMATCH_MS 2300
`define STOIM_IGNORE_CYC (`STOIM_IGNORE_US * `STOIM_CLK_MHZ)
`define STOIM_FILTER_CYC (`STOIM_FILTER_US * `STOIM_CLK_MHZ)
`define STOIM_MISMATCH_CYC (`STOIM_MISMATCH_MS * 1000 * `STOIM_CLK_MHZ)
`define STOIM_RST_LEVEL 1'h0

`endif

// file: stoim_monitor.sv
// dual-channel torque-off input monitor, top level
// assumes asynchronous request pins and same-clock firmware strobes
//
// Summary of operation
// - both channels low: tripped, no start, safe indicator on
// - both channels high: drive may run, safe indicator off
// - channels differ: tripped, no start, indicator off
// - mismatch up to 1.6 s gives no fault; agreement restores normal use
// - mismatch beyond 3.0 s always gives a fault
// - timeout enters fault without further input change
// - fault latches, trips, blocks start, indicator off until nrst reset
// - low test pulses under 2 ms cause nothing
// - a channel counts as low only after 6 ms continuous low
// - trip display pulses on blocked start, drop while running, fault
// - history entry on start while active or activation while running
// - no history entry when activated while not running
`timescale 1ns/100ps
`include "stoim_defs.svh"

module stoim_monitor #(
    parameter int FILTER_CYC = `STOIM_FILTER_CYC,
    parameter int IGNORE_CYC = `STOIM_IGNORE_CYC,
    parameter int MISMATCH_CYC = `STOIM_MISMATCH_CYC,
    parameter int MISMATCH_MIN_MS = `STOIM_MISMATCH_MIN_MS,
    parameter int MISMATCH_MAX_MS = `STOIM_MISMATCH_MAX_MS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic request_channel_a,
    input wire logic request_channel_b,
    input wire logic start_cmd,
    input wire logic drive_running,
    input wire logic circuit_fault,
    output logic safe_state_indicator,
    output logic run_permit,
    output logic start_block,
    output logic fault_latched,
    output stoim_pkg::stoim_state_t state_out,
    output logic trip_display_evt,
    output logic trip_history_evt
);
    import stoim_pkg::*;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    initial begin
        if (FILTER_CYC <= IGNORE_CYC) $error("filter must exceed ignore width");
        if (MISMATCH_CYC < 64'(MISMATCH_MIN_MS) * 64'(`STOIM_CLK_MHZ) * 64'd1000)
            $error("mismatch threshold below minimum");
        if (MISMATCH_CYC > 64'(MISMATCH_MAX_MS) * 64'(`STOIM_CLK_MHZ) * 64'd1000)
            $error("mismatch threshold above maximum");
    end

    // ------------------------------------------------------------
    // channel filtering
    // ------------------------------------------------------------
    logic chan_a;
    logic chan_b;

    stoim_chan_filter #(.FILTER_CYC(FILTER_CYC)) u_filt_a (
        .mclk(mclk),
        .nrst(nrst),
        .pin(request_channel_a),
        .level(chan_a)
    );

    stoim_chan_filter #(.FILTER_CYC(FILTER_CYC)) u_filt_b (
        .mclk(mclk),
        .nrst(nrst),
        .pin(request_channel_b),
        .level(chan_b)
    );

    // ------------------------------------------------------------
    // firmware inputs: same clock, taken directly
    // ------------------------------------------------------------
    logic circuit_fault_seen;
    assign circuit_fault_seen = circuit_fault;

    // ------------------------------------------------------------
    // mismatch timer
    // ------------------------------------------------------------
    logic [31:0] mis_cnt_reg;
    logic mis_expired;

    assign mis_expired = (mis_cnt_reg >= 32'(MISMATCH_CYC - 1)) && (chan_a != chan_b);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mis_cnt_reg <= 32'h0;
        end else if (chan_a == chan_b) begin
            mis_cnt_reg <= 32'h0;
        end else if (!mis_expired) begin
            mis_cnt_reg <= mis_cnt_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    stoim_state_t state_reg;
    stoim_state_t state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            STOIM_FAULT: begin
                state_next = STOIM_FAULT;
            end
            default: begin
                if (mis_expired || circuit_fault_seen) begin
                    state_next = STOIM_FAULT;
                end else if (chan_a && chan_b) begin
                    state_next = STOIM_RUN_OK;
                end else if (!chan_a && !chan_b) begin
                    state_next = STOIM_SAFE;
                end else begin
                    state_next = STOIM_DISAGREE;
                end
            end
        endcase
    end

    // reset starts in safe, so nothing runs before channels are re-read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= STOIM_SAFE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            safe_state_indicator <= 1'b0;
            run_permit <= 1'b0;
            start_block <= 1'b1;
            fault_latched <= 1'b0;
            state_out <= STOIM_SAFE;
        end else begin
            safe_state_indicator <= (state_next == STOIM_SAFE);
            run_permit <= (state_next == STOIM_RUN_OK);
            start_block <= (state_next != STOIM_RUN_OK);
            fault_latched <= (state_next == STOIM_FAULT);
            state_out <= state_next;
        end
    end

    // ------------------------------------------------------------
    // trip events
    // ------------------------------------------------------------
    logic torque_off;
    logic prev_torque_off_reg;
    logic prev_fault_reg;
    logic blocked_start;
    logic drop_running;
    logic new_fault;

    // torque is off whenever state_reg is not STOIM_RUN_OK, one cycle after a filtered channel goes low, or with fault latched
    assign torque_off = (state_reg != STOIM_RUN_OK);
    assign blocked_start = start_cmd && torque_off;
    assign drop_running = drive_running && torque_off && !prev_torque_off_reg;
    assign new_fault = (state_reg == STOIM_FAULT) && !prev_fault_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_torque_off_reg <= 1'b1;
            prev_fault_reg <= 1'b0;
        end else begin
            prev_torque_off_reg <= torque_off;
            prev_fault_reg <= (state_reg == STOIM_FAULT);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trip_display_evt <= 1'b0;
            trip_history_evt <= 1'b0;
        end else begin
            trip_display_evt <= blocked_start || drop_running || new_fault;
            // idle activation logs nothing: drive_running gates it
            trip_history_evt <= blocked_start || drop_running;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_disagree_long;
        (chan_a != chan_b) && (mis_cnt_reg == 32'(MISMATCH_CYC - 1));
    endsequence

    sequence s_fault_shown;
        fault_latched && !safe_state_indicator && start_block;
    endsequence

    a_fault_on_timeout: assert property (@(posedge mclk) disable iff (!nrst)
        s_disagree_long |=> s_fault_shown)
        else $error("timeout did not raise fault");

    a_fault_stays_latched: assert property (@(posedge mclk) disable iff (!nrst)
        (state_reg == STOIM_FAULT) |=> (state_reg == STOIM_FAULT))
        else $error("fault state left without reset");

    a_both_low_safe: assert property (@(posedge mclk) disable iff (!nrst)
        (!chan_a && !chan_b && state_reg != STOIM_FAULT && !mis_expired
         && !circuit_fault_seen) |=> safe_state_indicator && !run_permit)
        else $error("both low without safe indication");

    a_both_high_run: assert property (@(posedge mclk) disable iff (!nrst)
        (chan_a && chan_b && state_reg != STOIM_FAULT && !circuit_fault_seen)
        |=> run_permit && !safe_state_indicator)
        else $error("both high without run permit");

    a_mismatch_blocks: assert property (@(posedge mclk) disable iff (!nrst)
        (chan_a != chan_b) |=> start_block && !safe_state_indicator)
        else $error("mismatch did not block start");

    a_short_no_fault: assert property (@(posedge mclk) disable iff (!nrst)
        (state_reg != STOIM_FAULT && !circuit_fault_seen && chan_a != chan_b
         && mis_cnt_reg < 32'(MISMATCH_CYC - 1)) |=> !fault_latched)
        else $error("fault before mismatch threshold");

    a_timer_clears: assert property (@(posedge mclk) disable iff (!nrst)
        (chan_a == chan_b) |=> (mis_cnt_reg == 32'h0))
        else $error("mismatch timer not cleared");

    a_history_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (!start_cmd && !drive_running) |=> !trip_history_evt)
        else $error("history logged while idle");

    a_display_on_start: assert property (@(posedge mclk) disable iff (!nrst)
        (start_cmd && torque_off) |=> trip_display_evt && trip_history_evt)
        else $error("blocked start not reported");
endmodule // stoim_monitor

// file: stoim_pkg.sv
// types shared by the torque-off input monitor
// assumes nothing beyond the header of constants
package stoim_pkg;
    typedef enum logic [3:0] {
        STOIM_SAFE = 4'h1,
        STOIM_RUN_OK = 4'h2,
        STOIM_DISAGREE = 4'h4,
        STOIM_FAULT = 4'h8
    } stoim_state_t;
endpackage

// file: stoim_relay_model.sv
// model of the external safety relay that drives both request pins
// assumes demands and test strobes change on the falling edge of mclk
`timescale 1ns/100ps

module stoim_relay_model #(
    parameter int SKEW = 2,
    parameter int PULSE_W = 3
) (
    input wire logic mclk,
    input wire logic dem_a,
    input wire logic dem_b,
    input wire logic test_a,
    input wire logic test_b,
    output logic request_channel_a,
    output logic request_channel_b
);
    // ------------------------------
    // skew and test pulses
    // ------------------------------
    logic [7:0] b_hist = 8'h00;
    int pa_cnt = 0;
    int pb_cnt = 0;

    // contacts never close together: b always trails a a little
    always @(posedge mclk) begin
        b_hist <= {b_hist[6:0], dem_b};
    end

    // pulses kept below the ignore width so they must never trip the drive
    always @(posedge mclk) begin
        pa_cnt <= test_a ? PULSE_W : (pa_cnt > 0 ? pa_cnt - 1 : 0);
        pb_cnt <= test_b ? PULSE_W : (pb_cnt > 0 ? pb_cnt - 1 : 0);
    end

    assign request_channel_a = dem_a && pa_cnt == 0;
    assign request_channel_b = b_hist[SKEW - 1] && pb_cnt == 0;
endmodule // stoim_relay_model

// file: tb.sv
// self-checking bench for the torque-off input monitor
// assumes short sim counts: filter 8, ignore 4, mismatch 100 cycles
`timescale 1ns/100ps

module tb;
    import stoim_pkg::*;
    // ------------------------------
    // stimulus and instances
    // ------------------------------
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic dem_a = 1'h0;
    logic dem_b = 1'h0;
    logic test_a = 1'h0;
    logic test_b = 1'h0;
    logic start_cmd = 1'h0;
    logic drive_running = 1'h0;
    logic circuit_fault = 1'h0;
    logic pin_a, pin_b, safe_state_indicator, run_permit, start_block, fault_latched;
    logic trip_display_evt, trip_history_evt;
    stoim_state_t state_out;
    int miscompares = 0;
    int tests_run = 0;
    int h;

    always #5 mclk = ~mclk;

    stoim_relay_model u_relay (.mclk(mclk), .dem_a(dem_a), .dem_b(dem_b), .test_a(test_a),
        .test_b(test_b), .request_channel_a(pin_a), .request_channel_b(pin_b));

    stoim_monitor #(.FILTER_CYC(8), .IGNORE_CYC(4), .MISMATCH_CYC(100), .MISMATCH_MIN_MS(0),
        .MISMATCH_MAX_MS(1)) u_dut (.mclk(mclk), .nrst(nrst), .request_channel_a(pin_a),
        .request_channel_b(pin_b), .start_cmd(start_cmd), .drive_running(drive_running),
        .circuit_fault(circuit_fault), .safe_state_indicator(safe_state_indicator),
        .run_permit(run_permit), .start_block(start_block), .fault_latched(fault_latched),
        .state_out(state_out), .trip_display_evt(trip_display_evt),
        .trip_history_evt(trip_history_evt));

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic results;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: sig = run_permit;
            1: sig = fault_latched;
            2: sig = trip_display_evt;
            3: sig = safe_state_indicator;
            default: sig = trip_history_evt;
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // bounded wait; a spent bound ends the run
    task automatic wait_hi(input int sel, input int bound);
        int n;
        n = 0;
        while (sig(sel) !== 1'h1 && n < bound) begin
            @(negedge mclk);
            n++;
        end
        chk(sig(sel), 4'h1);
        if (sig(sel) !== 1'h1) results();
    endtask

    task automatic watch(input int sel, input int n, inout int hits);
        repeat (n) begin
            @(negedge mclk);
            if (sig(sel) === 1'h1) hits++;
        end
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset;
        cyc(3);
        chk(safe_state_indicator, 4'h1);
        chk(start_block, 4'h1);
        chk(state_out, STOIM_SAFE);
        $display("t_reset done");
    endtask

    task automatic t_start_blocked;
        start_cmd = 1'h1;
        cyc(1);
        start_cmd = 1'h0;
        wait_hi(2, 3);
        chk(trip_history_evt, 4'h1);
        chk(run_permit, 4'h0);
        $display("t_start_blocked done");
    endtask

    task automatic t_run;
        dem_a = 1'h1;
        dem_b = 1'h1;
        wait_hi(0, 20);
        chk(safe_state_indicator, 4'h0);
        chk(state_out, STOIM_RUN_OK);
        drive_running = 1'h1;
        start_cmd = 1'h1;
        cyc(1);
        start_cmd = 1'h0;
        h = 0;
        watch(2, 4, h);
        chk(h > 0 ? 4'h1 : 4'h0, 4'h0);
        $display("t_run done");
    endtask

    task automatic t_pulses;
        h = 0;
        test_a = 1'h1;
        cyc(1);
        test_a = 1'h0;
        watch(0, 8, h);
        test_b = 1'h1;
        cyc(1);
        test_b = 1'h0;
        watch(0, 20, h);
        chk(h != 28 ? 4'h1 : 4'h0, 4'h0);
        $display("t_pulses done");
    endtask

    task automatic t_drop_run;
        dem_a = 1'h0;
        dem_b = 1'h0;
        cyc(5);
        chk(run_permit, 4'h1);
        wait_hi(2, 40);
        chk(trip_history_evt, 4'h1);
        wait_hi(3, 40);
        chk(state_out, STOIM_SAFE);
        $display("t_drop_run done");
    endtask

    task automatic t_drop_idle;
        drive_running = 1'h0;
        dem_a = 1'h0;
        dem_b = 1'h0;
        h = 0;
        watch(4, 40, h);
        chk(h > 0 ? 4'h1 : 4'h0, 4'h0);
        $display("t_drop_idle done");
    endtask

    // two short mismatches whose sum passes the threshold
    task automatic t_mismatch_short;
        dem_a = 1'h1;
        cyc(50);
        chk(state_out, STOIM_DISAGREE);
        chk(safe_state_indicator | run_permit, 4'h0);
        dem_b = 1'h1;
        wait_hi(0, 20);
        dem_b = 1'h0;
        cyc(60);
        dem_b = 1'h1;
        wait_hi(0, 20);
        chk(fault_latched, 4'h0);
        $display("t_mismatch_short done");
    endtask

    task automatic t_mismatch_long;
        dem_b = 1'h0;
        wait_hi(1, 200);
        chk(state_out, STOIM_FAULT);
        dem_b = 1'h1;
        cyc(30);
        chk({fault_latched, run_permit, start_block, safe_state_indicator}, 4'hA);
        nrst = 1'h0;
        cyc(2);
        nrst = 1'h1;
        wait_hi(0, 30);
        chk(fault_latched, 4'h0);
        $display("t_mismatch_long done");
    endtask

    task automatic t_circuit;
        circuit_fault = 1'h1;
        cyc(1);
        circuit_fault = 1'h0;
        wait_hi(2, 4);
        wait_hi(1, 4);
        $display("t_circuit done");
    endtask

    initial begin
        cyc(12);
        nrst = 1'h1;
        t_reset();
        t_start_blocked();
        t_run();
        t_pulses();
        t_drop_run();
        t_run();
        t_drop_idle();
        t_mismatch_short();
        t_mismatch_long();
        t_circuit();
        results();
    end
endmodule // tb
